//--- core/slider_gesture_pkg.sv
/*
  Shared constants and types of the slider gesture recogniser: register offsets,
  field positions, reset values, gesture timing and the per-slider state type.
  Assumes a 20 MHz system clock; the gesture step is turned into cycles here, while the timeouts stay in steps.
*/

package slider_gesture_pkg;

  // System clock rate and gesture timer step.
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned GESTURE_STEP_MS = 16;
  localparam int unsigned GESTURE_STEP_CYCLES = (CLK_HZ / 1000) * GESTURE_STEP_MS;

  // Number of sliders and sensing channels.
  localparam int unsigned NUM_SLIDERS = 2;
  localparam int unsigned NUM_CHANNELS = 8;
  localparam int unsigned TIMER_W = 9;

  // Register offsets (word addresses on the register port).
  localparam logic [7:0] OFS_EVENT_STATUS = 8'h02;
  localparam logic [7:0] OFS_GESTURE_FLAGS = 8'h03;
  localparam logic [7:0] OFS_SETTINGS = 8'h80;
  localparam logic [7:0] OFS_EVENT_MASK = 8'h82;
  localparam logic [7:0] OFS_CHANNEL_SELECT = 8'h89;
  localparam logic [7:0] OFS_TIMEOUTS = 8'h8a;
  localparam logic [7:0] OFS_SWIPE_THRESHOLD = 8'h8b;

  // Field positions.
  localparam int unsigned SWIPE_MODE_BIT = 15;
  localparam int unsigned GESTURE_MASK_BIT = 11;
  localparam int unsigned GESTURE_EVENT_BIT = 11;
  localparam int unsigned FLAG_STRIDE = 4;
  localparam int unsigned FLAG_TAP = 0;
  localparam int unsigned FLAG_HOLD = 1;
  localparam int unsigned FLAG_POS = 2;
  localparam int unsigned FLAG_NEG = 3;

  // Values after reset.
  localparam logic [15:0] SETTINGS_RST = 16'h0000;
  localparam logic [15:0] EVENT_MASK_RST = 16'h0000;
  localparam logic [15:0] CHANNEL_SELECT_RST = 16'h0000;
  localparam logic [15:0] TIMEOUTS_RST = 16'h0f0a;
  localparam logic [7:0] SWIPE_THRESHOLD_RST = 8'h40;

  // Per-slider gesture tracking state.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_TOUCH,
    ST_HOLD,
    ST_DONE
  } gesture_state_t;

endpackage : slider_gesture_pkg

//--- core/input_sync3.sv
/*
  Three-stage synchroniser for a bus of asynchronous levels.
  Assumes each bit is an independent level; a bit's new value is accepted once
  the second and third stages agree on it.
*/

`timescale 1ns/1ps
`default_nettype none

module input_sync3 #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Levels.
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] stable_out
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  // Shift chain; the first stage feeds only the second.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Accept each bit once the two later stages agree.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stable_out <= '0;
    end else begin
      stable_out <= (s2_r & s3_r) | (stable_out & (s2_r | s3_r));
    end
  end

endmodule : input_sync3

`default_nettype wire

//--- core/step_tick.sv
/*
  Divider that produces a one-cycle enable pulse every PERIOD clock cycles.
  Assumes PERIOD is at least two.
*/

`timescale 1ns/1ps
`default_nettype none

module step_tick #(
  parameter int unsigned PERIOD = 320000
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Enable pulse.
  output logic tick_out
);

  logic [31:0] count_r;

  // Count up and pulse when the count wraps.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_r <= 32'h0000_0000;
      tick_out <= 1'b0;
    end else if (count_r == 32'(PERIOD - 1)) begin
      count_r <= 32'h0000_0000;
      tick_out <= 1'b1;
    end else begin
      count_r <= count_r + 32'h0000_0001;
      tick_out <= 1'b0;
    end
  end

endmodule : step_tick

`default_nettype wire

//--- core/slider_gesture_detect.sv
/*
  Gesture recogniser for two sliders: tap, hold, flick and swipe detection,
  per-slider direction flags and a maskable global gesture event, reached
  through a simple word-wide register port.
  Assumes channel touch states arrive asynchronously from the sensing front end,
  and that slider coordinates come from same-clock logic, rising from the
  lowest selected channel toward the highest.
*/

`timescale 1ns/1ps
`default_nettype none

module slider_gesture_detect #(
  parameter int unsigned STEP_CYCLES = slider_gesture_pkg::GESTURE_STEP_CYCLES
) (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  // Channel touch states from the sensing front end.
  input wire logic [7:0] channel_touch_in,
  // Slider coordinates from the position estimator.
  input wire logic [7:0] slider0_coord_in,
  input wire logic [7:0] slider1_coord_in,
  // Register port.
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // Global gesture event level.
  output logic gesture_event_out
);

  localparam int unsigned NS = slider_gesture_pkg::NUM_SLIDERS;
  localparam int unsigned TW = slider_gesture_pkg::TIMER_W;

  // Reset release synchroniser.
  logic rst_meta_r;
  logic rst_n;

  // Configuration registers.
  logic [15:0] settings_r;
  logic [15:0] event_mask_r;
  logic [15:0] channel_select_r;
  logic [15:0] timeouts_r;
  logic [7:0] swipe_threshold_r;

  // Status.
  logic [7:0] gesture_flags_r;
  logic gesture_event_r;

  // Shared signals.
  logic [7:0] touch_stable;
  logic step_tick;
  logic swipe_mode;
  logic [TW-1:0] tap_limit;
  logic [TW-1:0] swipe_limit;
  logic [8:0] threshold_full;
  logic [8:0] threshold_half;
  logic [7:0] coord_w [NS];

  // Per-slider gesture pulses and hold levels.
  logic [NS-1:0] tap_ev;
  logic [NS-1:0] motion_ev;
  logic [NS-1:0] motion_dir_negative_flag;
  logic [NS-1:0] hold_ev;
  logic [NS-1:0] hold_level;

  // Register port decodes.
  logic rd_status;
  logic rd_flags;

  // Tells whether any channel chosen for a slider is touched.
  function automatic logic slider_touched(input logic [7:0] sel, input logic [7:0] touch);
    slider_touched = |(sel & touch);
  endfunction : slider_touched

  // Magnitude of a signed coordinate difference.
  function automatic logic [8:0] magnitude(input logic signed [8:0] d);
    magnitude = d[8] ? 9'(-d) : 9'(d);
  endfunction : magnitude

  // Two-stage release of the asynchronous reset.
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // Touch states cross into the clock domain through three stages.
  input_sync3 #(
    .WIDTH(slider_gesture_pkg::NUM_CHANNELS)
  ) touch_sync (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n),
    .async_in(channel_touch_in),
    .stable_out(touch_stable)
  );

  step_tick #(
    .PERIOD(STEP_CYCLES)
  ) gesture_step (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n),
    .tick_out(step_tick)
  );

  // Configuration fields used by the slider state machines.
  // one mode bit for both
  assign swipe_mode = settings_r[slider_gesture_pkg::SWIPE_MODE_BIT];
  assign tap_limit = {1'b0, timeouts_r[7:0]};
  assign swipe_limit = {1'b0, timeouts_r[15:8]};
  assign threshold_full = {1'b0, swipe_threshold_r};
  assign threshold_half = {2'b00, swipe_threshold_r[7:1]};
  assign coord_w[0] = slider0_coord_in;
  assign coord_w[1] = slider1_coord_in;

  // Read strobes that clear sticky status.
  assign rd_status = reg_rd_in && (reg_addr_in == slider_gesture_pkg::OFS_EVENT_STATUS);
  assign rd_flags = reg_rd_in && (reg_addr_in == slider_gesture_pkg::OFS_GESTURE_FLAGS);

  for (genvar g = 0; g < NS; g++) begin : gen_slider
    slider_gesture_pkg::gesture_state_t state_r;
    slider_gesture_pkg::gesture_state_t state_nxt;
    logic [TW-1:0] timer_r;
    logic [7:0] start_coord_r;
    logic touched;
    logic signed [8:0] delta;
    logic [8:0] distance;
    logic beyond_timeouts;
    logic tap_nxt;
    logic motion_nxt;
    logic hold_nxt;

    assign touched = slider_touched(channel_select_r[8*g +: 8], touch_stable);
    assign delta = $signed({1'b0, coord_w[g]}) - $signed({1'b0, start_coord_r});
    assign distance = magnitude(delta);
    assign beyond_timeouts = (timer_r > tap_limit) && (timer_r > swipe_limit);

    // Gesture decisions for this slider.
    always_comb begin
      state_nxt = state_r;
      tap_nxt = 1'b0;
      motion_nxt = 1'b0;
      hold_nxt = 1'b0;
      unique case (state_r)
        slider_gesture_pkg::ST_IDLE: begin
          if (touched) begin
            state_nxt = slider_gesture_pkg::ST_TOUCH;
          end
        end
        slider_gesture_pkg::ST_TOUCH: begin
          if (!touched) begin
            state_nxt = slider_gesture_pkg::ST_IDLE;
            if ((timer_r < tap_limit) && (distance <= threshold_half)) begin
              tap_nxt = 1'b1;
            end else if (!swipe_mode && (distance > threshold_half) && (timer_r < swipe_limit)) begin
              motion_nxt = 1'b1;
            end
          end else if (swipe_mode && (distance > threshold_full) && (timer_r < swipe_limit)) begin
            motion_nxt = 1'b1;
            state_nxt = slider_gesture_pkg::ST_DONE;
          end else if (beyond_timeouts) begin
            hold_nxt = 1'b1;
            state_nxt = slider_gesture_pkg::ST_HOLD;
          end
        end
        slider_gesture_pkg::ST_HOLD: begin
          if (!touched) begin
            state_nxt = slider_gesture_pkg::ST_IDLE;
          end
        end
        slider_gesture_pkg::ST_DONE: begin
          if (!touched) begin
            state_nxt = slider_gesture_pkg::ST_IDLE;
          end
        end
      endcase
    end

    // State register.
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
        state_r <= slider_gesture_pkg::ST_IDLE;
      end else begin
        state_r <= state_nxt;
      end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
        timer_r <= '0;
      end else if (state_r == slider_gesture_pkg::ST_IDLE) begin
        timer_r <= '0;
      end else if (step_tick && (timer_r != {TW{1'b1}})) begin
        timer_r <= timer_r + TW'(1);
      end
    end

    // Coordinate at first touch, the reference for movement.
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
        start_coord_r <= 8'h00;
      end else if ((state_r == slider_gesture_pkg::ST_IDLE) && touched) begin
        start_coord_r <= coord_w[g];
      end
    end

    assign tap_ev[g] = tap_nxt;
    assign motion_ev[g] = motion_nxt;
    assign motion_dir_negative_flag[g] = delta[8];
    assign hold_ev[g] = hold_nxt;
    assign hold_level[g] = (state_r == slider_gesture_pkg::ST_HOLD);
  end

  // Tells whether a slider's hold ends in this cycle.
  function automatic logic state_is_leaving(input int s);
    state_is_leaving = hold_level[s] && !slider_touched(channel_select_r[8*s +: 8], touch_stable);
  endfunction : state_is_leaving

  // Sticky tap and direction flags; reading the flag byte clears them, but an
  // event in the same cycle still lands.
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      gesture_flags_r <= 8'h00;
    end else begin
      for (int s = 0; s < NS; s++) begin
        gesture_flags_r[s*slider_gesture_pkg::FLAG_STRIDE + slider_gesture_pkg::FLAG_TAP] <=
          tap_ev[s] |
          (gesture_flags_r[s*slider_gesture_pkg::FLAG_STRIDE + slider_gesture_pkg::FLAG_TAP] & ~rd_flags);
        gesture_flags_r[s*slider_gesture_pkg::FLAG_STRIDE + slider_gesture_pkg::FLAG_POS] <=
          (motion_ev[s] & ~motion_dir_negative_flag[s]) |
          (gesture_flags_r[s*slider_gesture_pkg::FLAG_STRIDE + slider_gesture_pkg::FLAG_POS] & ~rd_flags);
        gesture_flags_r[s*slider_gesture_pkg::FLAG_STRIDE + slider_gesture_pkg::FLAG_NEG] <=
          (motion_ev[s] & motion_dir_negative_flag[s]) |
          (gesture_flags_r[s*slider_gesture_pkg::FLAG_STRIDE + slider_gesture_pkg::FLAG_NEG] & ~rd_flags);
        gesture_flags_r[s*slider_gesture_pkg::FLAG_STRIDE + slider_gesture_pkg::FLAG_HOLD] <=
          hold_ev[s] | (hold_level[s] & ~(state_is_leaving(s)));
      end
    end
  end

  // Global gesture event: set on any gesture unless masked, cleared by a read
  // of the event status word, with a new event winning over the clear.
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      gesture_event_r <= 1'b0;
    end else if (!event_mask_r[slider_gesture_pkg::GESTURE_MASK_BIT] &&
                 (|(tap_ev | motion_ev | hold_ev))) begin
      gesture_event_r <= 1'b1;
    end else if (rd_status) begin
      gesture_event_r <= 1'b0;
    end
  end

  // Event level mirrored on its own output flop.
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      gesture_event_out <= 1'b0;
    end else begin
      gesture_event_out <= gesture_event_r;
    end
  end

  // Configuration writes; writes to other offsets are ignored.
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      settings_r <= slider_gesture_pkg::SETTINGS_RST;
      event_mask_r <= slider_gesture_pkg::EVENT_MASK_RST;
      channel_select_r <= slider_gesture_pkg::CHANNEL_SELECT_RST;
      timeouts_r <= slider_gesture_pkg::TIMEOUTS_RST;
      swipe_threshold_r <= slider_gesture_pkg::SWIPE_THRESHOLD_RST;
    end else if (reg_wr_in) begin
      unique case (reg_addr_in)
        slider_gesture_pkg::OFS_SETTINGS: begin
          settings_r <= reg_wdata_in;
        end
        slider_gesture_pkg::OFS_EVENT_MASK: begin
          event_mask_r <= reg_wdata_in;
        end
        slider_gesture_pkg::OFS_CHANNEL_SELECT: begin
          channel_select_r <= reg_wdata_in;
        end
        slider_gesture_pkg::OFS_TIMEOUTS: begin
          timeouts_r <= reg_wdata_in;
        end
        slider_gesture_pkg::OFS_SWIPE_THRESHOLD: begin
          swipe_threshold_r <= reg_wdata_in[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Registered read data one cycle after the read strobe; unmapped reads give zero.
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_out <= 16'h0000;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        unique case (reg_addr_in)
          slider_gesture_pkg::OFS_EVENT_STATUS: begin
            reg_rdata_out <= 16'(gesture_event_r) << slider_gesture_pkg::GESTURE_EVENT_BIT;
          end
          slider_gesture_pkg::OFS_GESTURE_FLAGS: begin
            reg_rdata_out <= {8'h00, gesture_flags_r};
          end
          slider_gesture_pkg::OFS_SETTINGS: begin
            reg_rdata_out <= settings_r;
          end
          slider_gesture_pkg::OFS_EVENT_MASK: begin
            reg_rdata_out <= event_mask_r;
          end
          slider_gesture_pkg::OFS_CHANNEL_SELECT: begin
            reg_rdata_out <= channel_select_r;
          end
          slider_gesture_pkg::OFS_TIMEOUTS: begin
            reg_rdata_out <= timeouts_r;
          end
          slider_gesture_pkg::OFS_SWIPE_THRESHOLD: begin
            reg_rdata_out <= {8'h00, swipe_threshold_r};
          end
          default: begin
            reg_rdata_out <= 16'h0000;
          end
        endcase
      end
    end
  end

endmodule : slider_gesture_detect

`default_nettype wire

//--- verification/slider_gesture_detect_asserts.sv
/*
  Concurrent checks on the ports of the slider gesture recogniser, bound into it.
  Assumes the register port contract of the design and one clock domain.
*/

`timescale 1ns/1ps
`default_nettype none

module slider_gesture_detect_asserts #(
  parameter int unsigned STEP_CYCLES = slider_gesture_pkg::GESTURE_STEP_CYCLES
) (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  // Gesture inputs.
  input wire logic [7:0] channel_touch_in,
  input wire logic [7:0] slider0_coord_in,
  input wire logic [7:0] slider1_coord_in,
  // Register port.
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire logic gesture_event_out
);
  logic [15:0] sel_r;
  logic [15:0] tmo_r;
  logic [7:0] thr_r;
  logic mode_r;
  logic mask_r;
  logic rd_status;
  logic mapped;

  // Decodes of the read that clears the event and of the mapped offsets.
  assign rd_status = reg_rd_in && (reg_addr_in == slider_gesture_pkg::OFS_EVENT_STATUS);
  assign mapped = reg_addr_in inside {8'h02, 8'h03, 8'h80, 8'h82, 8'h89, 8'h8a, 8'h8b};

  // Shadow copies of the writable settings, so readbacks can be judged.
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sel_r <= slider_gesture_pkg::CHANNEL_SELECT_RST;
      tmo_r <= slider_gesture_pkg::TIMEOUTS_RST;
      thr_r <= slider_gesture_pkg::SWIPE_THRESHOLD_RST;
      mode_r <= slider_gesture_pkg::SETTINGS_RST[15];
      mask_r <= slider_gesture_pkg::EVENT_MASK_RST[11];
    end else if (reg_wr_in) begin
      if (reg_addr_in == 8'h89) sel_r <= reg_wdata_in;
      if (reg_addr_in == 8'h8a) tmo_r <= reg_wdata_in;
      if (reg_addr_in == 8'h8b) thr_r <= reg_wdata_in[7:0];
      if (reg_addr_in == 8'h80) mode_r <= reg_wdata_in[15];
      if (reg_addr_in == 8'h82) mask_r <= reg_wdata_in[11];
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);

  // A read of one register offset.
  sequence s_rd(logic [7:0] a);
    reg_rd_in && (reg_addr_in == a);
  endsequence

  a_read_answer: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("read not answered in the next cycle");
  a_answer_cause: assert property (reg_rvalid_out |-> $past(reg_rd_in))
    else $error("read answer without a read");
  a_rdata_hold: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data changed without a read");
  a_select_readback: assert property (s_rd(8'h89) |=> reg_rdata_out == sel_r)
    else $error("channel selection readback wrong");
  a_timeout_readback: assert property (s_rd(8'h8a) |=> reg_rdata_out == tmo_r)
    else $error("timeout readback wrong");
  a_thresh_readback: assert property (s_rd(8'h8b) |=> reg_rdata_out[7:0] == thr_r)
    else $error("threshold readback wrong");
  a_mode_readback: assert property (s_rd(8'h80) |=> reg_rdata_out[15] == mode_r)
    else $error("mode bit readback wrong");
  a_mask_readback: assert property (s_rd(8'h82) |=> reg_rdata_out[11] == mask_r)
    else $error("mask bit readback wrong");
  a_unmapped_zero: assert property (reg_rd_in && !mapped |=> reg_rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  a_mask_blocks: assert property ($rose(gesture_event_out) |-> !$past(mask_r, 2) && !$past(mask_r, 3))
    else $error("gesture event raised while masked");
  a_event_clear_read: assert property ($fell(gesture_event_out) |-> $past(rd_status, 2))
    else $error("gesture event fell without a status read");

endmodule : slider_gesture_detect_asserts

bind slider_gesture_detect slider_gesture_detect_asserts #(.STEP_CYCLES(STEP_CYCLES)) i_asserts (
  .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .channel_touch_in(channel_touch_in),
  .slider0_coord_in(slider0_coord_in), .slider1_coord_in(slider1_coord_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .reg_rvalid_out(reg_rvalid_out), .gesture_event_out(gesture_event_out));

`default_nettype wire

//--- verification/host_model.sv
/*
  Host side of the register port: one-cycle write and read strobes.
  Assumes the design answers a read one cycle after the strobe edge.
*/

`timescale 1ns/1ps
`default_nettype none

module host_model (
  // Clock.
  input wire logic clk_in,
  // Register port towards the design.
  output logic [7:0] reg_addr_out,
  output logic [15:0] reg_wdata_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  input wire logic [15:0] reg_rdata_in,
  input wire logic reg_rvalid_in
);
  // Idle values at time zero.
  initial begin
    reg_addr_out = 8'h00;
    reg_wdata_out = 16'h0000;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
  end

  // One write strobe, driven just after a rising edge.
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    #2;
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    @(posedge clk_in);
    #2;
    reg_wr_out = 1'b0;
  endtask : write_reg

  // One read strobe; unknown data comes back when no answer appears.
  task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_in);
    #2;
    reg_addr_out = a;
    reg_rd_out = 1'b1;
    @(posedge clk_in);
    #2;
    reg_rd_out = 1'b0;
    d = (reg_rvalid_in === 1'b1) ? reg_rdata_in : 16'hxxxx;
  endtask : read_reg

endmodule : host_model

`default_nettype wire

//--- verification/tb.sv
/*
  Self-checking bench of the slider gesture recogniser: register tasks, gesture stimulus.
  Assumes a short timer step parameter and the host model on the register port.
*/

`timescale 1ns/1ps
`default_nettype none

module tb;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] touch = 8'h00;
  logic [7:0] coord0 = 8'h80;
  logic [7:0] coord1 = 8'h80;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic wr;
  logic rd;
  logic rvalid;
  logic evt;
  int errors = 0;
  int checked = 0;

  // Clock at 20 MHz.
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  slider_gesture_detect #(.STEP_CYCLES(8)) i_dut (
    .sys_clk_in(sys_clk), .arst_n_in(arst_n), .channel_touch_in(touch), .slider0_coord_in(coord0),
    .slider1_coord_in(coord1), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .gesture_event_out(evt));

  host_model i_host (
    .clk_in(sys_clk), .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rd),
    .reg_rdata_in(rdata), .reg_rvalid_in(rvalid));

  // Compares one value and counts the outcome.
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude

  // Reads a register and compares the bits under a mask.
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] exp);
    logic [15:0] d;
    i_host.read_reg(a, d);
    check($sformatf("reg %h", a), d & m, exp);
  endtask : rd_chk

  // Waits n edges and lands just after the last one.
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : step

  // Touch, move by delta, release, then judge flags, event level and clearing.
  task automatic gesture(input int s, input int len, input int delta, input logic [7:0] fl, input logic ev);
    touch = (s == 1) ? 8'h10 : 8'h01;
    step(10);
    if (s == 1) coord1 = 8'(128 + delta);
    else coord0 = 8'(128 + delta);
    step(len);
    touch = 8'h00;
    step(12);
    check("event level", {15'h0000, evt}, {15'h0000, ev});
    rd_chk(8'h03, 16'h00ff, {8'h00, fl});
    rd_chk(8'h02, 16'h0800, ev ? 16'h0800 : 16'h0000);
    rd_chk(8'h03, 16'h00ff, 16'h0000);
    coord0 = 8'h80;
    coord1 = 8'h80;
  endtask : gesture

  // Cuts a hang short.
  initial begin
    repeat (100000) @(posedge sys_clk);
    errors++;
    conclude();
  end

  // Main sequence.
  initial begin
    repeat (16) @(posedge sys_clk);
    #2;
    arst_n = 1'b1;
    step(4);
    rd_chk(8'h80, 16'hffff, slider_gesture_pkg::SETTINGS_RST);
    rd_chk(8'h82, 16'hffff, slider_gesture_pkg::EVENT_MASK_RST);
    rd_chk(8'h8a, 16'hffff, slider_gesture_pkg::TIMEOUTS_RST);
    rd_chk(8'h8b, 16'h00ff, {8'h00, slider_gesture_pkg::SWIPE_THRESHOLD_RST});
    rd_chk(8'h55, 16'hffff, 16'h0000);
    i_host.write_reg(8'h03, 16'hffff);
    rd_chk(8'h03, 16'hffff, 16'h0000);
    i_host.write_reg(8'h89, 16'hf00f);
    rd_chk(8'h89, 16'hffff, 16'hf00f);
    gesture(0, 20, 0, 8'h01, 1'b1);
    gesture(0, 20, 32, 8'h01, 1'b1);
    gesture(0, 20, 33, 8'h04, 1'b1);
    gesture(1, 20, -40, 8'h80, 1'b1);
    gesture(1, 20, 0, 8'h10, 1'b1);
    // Hold on slider 0 survives a flag read while touched.
    touch = 8'h02;
    step(200);
    rd_chk(8'h03, 16'h00ff, 16'h0002);
    rd_chk(8'h03, 16'h00ff, 16'h0002);
    touch = 8'h00;
    step(12);
    rd_chk(8'h03, 16'h00ff, 16'h0000);
    rd_chk(8'h02, 16'h0800, 16'h0800);
    // A shortened tap timeout turns a still touch on slider 0 into nothing.
    i_host.write_reg(8'h8a, 16'h0f02);
    gesture(0, 30, 0, 8'h00, 1'b0);
    i_host.write_reg(8'h8a, 16'h0f0a);
    // Swipe mode reports without a release.
    i_host.write_reg(8'h80, 16'h8000);
    touch = 8'h04;
    step(10);
    coord0 = 8'd193;
    step(8);
    rd_chk(8'h03, 16'h00ff, 16'h0004);
    touch = 8'h00;
    step(12);
    rd_chk(8'h03, 16'h00ff, 16'h0000);
    rd_chk(8'h02, 16'h0800, 16'h0800);
    coord0 = 8'h80;
    // Masked gestures keep their flags but raise no event.
    i_host.write_reg(8'h80, 16'h0000);
    i_host.write_reg(8'h82, 16'h0800);
    gesture(0, 20, 0, 8'h01, 1'b0);
    conclude();
  end

endmodule : tb

`default_nettype wire
